// >>> rwp_top.sv
// RAM subsystem: AHB port, DMA arbiter, write-protection unit, APB registers
`timescale 1ns/1ps
`default_nettype none
module rwp_top
    import rwp_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                reset_n,
    // AHB slave, RAM port
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [3:0]          hprot,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hreadyin,
    output logic [31:0]              hrdata,
    output logic                     hready,
    output logic [1:0]               hresp,
    // DMA channels
    input  wire logic [NUM_DMA-1:0]  dma_req,
    input  wire logic [NUM_DMA-1:0]  dma_write,
    input  wire logic [31:0]         dma_addr [NUM_DMA],
    input  wire logic [31:0]         dma_wdata [NUM_DMA],
    output logic [NUM_DMA-1:0]       dma_grant,
    output logic [NUM_DMA-1:0]       dma_rvalid,
    output logic [31:0]              dma_rdata,
    // APB slave, register port
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Interrupt
    output logic                     irq
);
    import rwp_pkg::*;

    typedef enum logic [1:0] {
        AHB_IDLE  = 2'b00,
        AHB_WAIT  = 2'b01,
        AHB_ERR1  = 2'b10,
        AHB_ERR2  = 2'b11
    } rwp_ahb_state_type;

    rwp_ahb_state_type ahb_state;

    logic [31:0]            prot_map [MAP_REGS];
    logic                   dma_check_en;
    logic                   fast_clk;
    logic [NUM_EVENTS-1:0]  irq_status;
    logic [NUM_EVENTS-1:0]  irq_mask;
    logic [31:0]            fault_addr;
    logic [2:0]             fault_id;

    // Address-phase capture
    logic                   dp_write;
    logic [RAM_AW-1:0]      dp_word;
    logic [3:0]             dp_be;
    logic [1:0]             wait_cnt;
    logic                   dp_read;

    // Protection lookup on a byte address offset
    function automatic logic is_protected(input logic [31:0] a);
        logic [31:0] off;
        logic [8:0]  blk;
        off = a - RAM_BASE;
        blk = off[BLOCK_SHIFT +: 9];
        is_protected = prot_map[blk[8:5]][blk[4:0]];
    endfunction

    function automatic logic in_ram(input logic [31:0] a);
        in_ram = (a >= RAM_BASE) && (a < RAM_BASE + RAM_BYTES);
    endfunction

    // AHB address-phase decode
    logic ahb_start;
    logic ahb_ok_addr;
    logic ahb_user;
    logic ahb_deny;
    logic [3:0] ahb_be;
    assign ahb_start   = hsel && hreadyin && htrans[1] && (ahb_state == AHB_IDLE);
    assign ahb_ok_addr = in_ram(haddr);
    assign ahb_user    = !hprot[1];
    assign ahb_deny    = hwrite && ahb_user && ahb_ok_addr && is_protected(haddr);

    // Byte enables from size and low address bits
    always_comb begin
        case (hsize)
            HSIZE_BYTE: ahb_be = 4'h1 << haddr[1:0];
            HSIZE_HALF: ahb_be = haddr[1] ? 4'hc : 4'h3;
            default:    ahb_be = 4'hf;
        endcase
    end

    // AHB response sequencing; errors use the two-cycle response
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ahb_state <= AHB_IDLE;
            wait_cnt  <= 2'h0;
        end else begin
            case (ahb_state)
                AHB_IDLE: begin
                    if (ahb_start && (ahb_deny || !ahb_ok_addr)) begin
                        ahb_state <= AHB_ERR1;
                    end else if (ahb_start && fast_clk) begin
                        ahb_state <= AHB_WAIT;
                        wait_cnt  <= 2'(WAIT_STATES_FAST);
                    end
                end
                AHB_WAIT: begin
                    if (wait_cnt == 2'h0) begin
                        ahb_state <= AHB_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 2'h1;
                    end
                end
                AHB_ERR1: ahb_state <= AHB_ERR2;
                AHB_ERR2: ahb_state <= AHB_IDLE;
                default:  ahb_state <= AHB_IDLE;
            endcase
        end
    end

    // Capture the accepted transfer for the data phase
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_word  <= '0;
            dp_be    <= 4'h0;
        end else if (ahb_start && ahb_ok_addr && !ahb_deny) begin
            dp_write <= hwrite;
            dp_read  <= !hwrite;
            dp_word  <= RAM_AW'((haddr - RAM_BASE) >> 2);
            dp_be    <= ahb_be;
        end else if (hready) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
        end
    end

    assign hready = (ahb_state == AHB_IDLE) || (ahb_state == AHB_ERR2) ||
                    ((ahb_state == AHB_WAIT) && (wait_cnt == 2'h0));
    assign hresp  = ((ahb_state == AHB_ERR1) || (ahb_state == AHB_ERR2)) ?
                    HRESP_ERROR : HRESP_OKAY;

    // DMA arbitration; a host data phase owns the RAM port, so waited reads keep their data
    logic [2:0]  arb_id;
    logic        arb_any;
    logic        host_port;
    assign host_port = dp_write || dp_read || ahb_start;

    rwp_dma_arbiter #(.N(NUM_DMA)) u_arb (
        .req       (dma_req),
        .blocked   (host_port),
        .grant     (dma_grant),
        .grant_id  (arb_id),
        .grant_any (arb_any)
    );

    logic [31:0] g_addr;
    logic [31:0] g_off;
    logic        g_write;
    logic        g_legal;
    logic        g_fault;
    assign g_addr  = dma_addr[arb_id];
    assign g_off   = g_addr - RAM_BASE;
    assign g_write = dma_write[arb_id] && DMA_WRITERS[arb_id];
    assign g_legal = in_ram(g_addr);
    assign g_fault = arb_any && g_write && g_legal && dma_check_en && is_protected(g_addr);

    // Shared RAM port mux: host write data phase, host read start, else DMA
    logic              ram_en;
    logic [3:0]        ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [31:0]       ram_wdata;
    logic [31:0]       ram_rdata;
    always_comb begin
        if (dp_write) begin
            ram_en    = 1'b1;
            ram_we    = dp_be;
            ram_addr  = dp_word;
            ram_wdata = hwdata;
        end else if (ahb_start && ahb_ok_addr && !hwrite) begin
            ram_en    = 1'b1;
            ram_we    = 4'h0;
            ram_addr  = RAM_AW'((haddr - RAM_BASE) >> 2);
            ram_wdata = 32'h0;
        end else begin
            ram_en    = arb_any && g_legal;
            ram_we    = (g_write && !g_fault) ? 4'hf : 4'h0;
            ram_addr  = RAM_AW'(g_off >> 2);
            ram_wdata = dma_wdata[arb_id];
        end
    end

    rwp_ram #(.WORDS(RAM_WORDS), .AW(RAM_AW)) u_ram (
        .mclk  (mclk),
        .en    (ram_en),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    assign hrdata    = ram_rdata;
    assign dma_rdata = ram_rdata;

    // Read data for a DMA channel is valid the cycle after its grant
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dma_rvalid <= '0;
        end else begin
            dma_rvalid <= (arb_any && !dma_write[arb_id]) ? dma_grant : '0;
        end
    end

    // APB decode, zero-wait answer
    logic        apb_wr;
    logic [11:0] p_off;
    logic        p_map;
    logic        p_hit;
    assign p_off  = paddr[11:0];
    assign p_map  = (p_off < REG_MAP0 + 12'(MAP_REGS * 4));
    assign p_hit  = p_map || (p_off == REG_CTRL) || (p_off == REG_STATUS) ||
                    (p_off == REG_MASK) || (p_off == REG_FAULT_ADDR) ||
                    (p_off == REG_FAULT_ID);
    assign apb_wr = psel && penable && pwrite && p_hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!p_hit || (paddr[1:0] != 2'h0));

    // Protection bitmap
    genvar gi;
    generate
        for (gi = 0; gi < MAP_REGS; gi++) begin : g_map
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    prot_map[gi] <= 32'h0;
                end else if (apb_wr && (p_off == REG_MAP0 + 12'(gi * 4))) begin
                    prot_map[gi] <= pwdata;
                end
            end
        end
    endgenerate

    // Control and mask
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dma_check_en <= 1'b0;
            fast_clk     <= 1'b0;
            irq_mask     <= '0;
        end else if (apb_wr) begin
            if (p_off == REG_CTRL) begin
                dma_check_en <= pwdata[CTRL_DMA_CHK];
                fast_clk     <= pwdata[CTRL_FAST_CLK];
            end
            if (p_off == REG_MASK) begin
                irq_mask <= pwdata[NUM_EVENTS-1:0];
            end
        end
    end

    // Sticky status: hardware set wins over a write-one clear
    logic [NUM_EVENTS-1:0] ev_set;
    logic [NUM_EVENTS-1:0] ev_clr;
    assign ev_set[ST_DMA_FAULT] = g_fault;
    assign ev_set[ST_BUS_FAULT] = ahb_start && ahb_deny;
    assign ev_clr = (apb_wr && (p_off == REG_STATUS)) ? pwdata[NUM_EVENTS-1:0] : '0;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~ev_clr) | ev_set;
        end
    end

    // Fault capture on every protected DMA write while DMA checking is enabled
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fault_addr <= 32'h0;
            fault_id   <= 3'h0;
        end else if (g_fault) begin
            fault_addr <= g_addr;
            fault_id   <= arb_id;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // APB read data from flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0;
            if (p_map) begin
                prdata <= prot_map[p_off[5:2]];
            end else begin
                case (p_off)
                    REG_CTRL:       prdata <= {30'h0, fast_clk, dma_check_en};
                    REG_STATUS:     prdata <= {30'h0, irq_status};
                    REG_MASK:       prdata <= {30'h0, irq_mask};
                    REG_FAULT_ADDR: prdata <= fault_addr;
                    REG_FAULT_ID:   prdata <= {29'h0, fault_id};
                    default:        prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> rwp_pkg.sv
// Package: constants for the RAM subsystem with write protection and DMA arbiter
package rwp_pkg;
    // Address map
    localparam logic [31:0] RAM_BASE        = 32'h2000_0000;
    localparam int          RAM_BYTES       = 12288;
    localparam logic [31:0] PERIPH_BASE     = 32'h4000_0000;
    localparam int          RAM_WORDS       = RAM_BYTES / 4;
    localparam int          RAM_AW          = 12;
    localparam int          BLOCK_SHIFT     = 5;
    localparam int          NUM_BLOCKS      = RAM_BYTES / 32;
    localparam int          MAP_REGS        = NUM_BLOCKS / 32;
    localparam int          WAIT_STATES_FAST = 2;

    // DMA channels: index 0 is highest priority
    localparam int          NUM_DMA         = 6;
    localparam logic [2:0]  CH_MAC_RX       = 3'h0;
    localparam logic [2:0]  CH_MAC_TX       = 3'h1;
    localparam logic [2:0]  CH_SC1_RX       = 3'h2;
    localparam logic [2:0]  CH_SC1_TX       = 3'h3;
    localparam logic [2:0]  CH_SC2_RX       = 3'h4;
    localparam logic [2:0]  CH_SC2_TX       = 3'h5;
    // Channels permitted to write the RAM
    localparam logic [5:0]  DMA_WRITERS     = 6'h15;

    // APB register offsets (byte addresses within the block)
    localparam logic [11:0] REG_MAP0        = 12'h000;
    localparam logic [11:0] REG_CTRL        = 12'h040;
    localparam logic [11:0] REG_STATUS      = 12'h044;
    localparam logic [11:0] REG_MASK        = 12'h048;
    localparam logic [11:0] REG_FAULT_ADDR  = 12'h04c;
    localparam logic [11:0] REG_FAULT_ID    = 12'h050;

    // Field positions
    localparam int          CTRL_DMA_CHK    = 0;
    localparam int          CTRL_FAST_CLK   = 1;
    localparam int          ST_DMA_FAULT    = 0;
    localparam int          ST_BUS_FAULT    = 1;
    localparam int          NUM_EVENTS      = 2;

    // AHB encodings
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0]  HRESP_OKAY      = 2'h0;
    localparam logic [1:0]  HRESP_ERROR     = 2'h1;
    localparam logic [2:0]  HSIZE_BYTE      = 3'h0;
    localparam logic [2:0]  HSIZE_HALF      = 3'h1;
endpackage

// >>> rwp_dma_arbiter.sv
// Fixed-priority grant among the DMA channels
`timescale 1ns/1ps
`default_nettype none
module rwp_dma_arbiter #(
    parameter int N = 6
) (
    // Requests and grant
    input  wire logic [N-1:0] req,
    input  wire logic         blocked,
    output logic [N-1:0]      grant,
    output logic [2:0]        grant_id,
    output logic              grant_any
);
    import rwp_pkg::*;

    // Lowest index wins; blocked holds every channel off
    always_comb begin
        grant     = '0;
        grant_id  = 3'h0;
        grant_any = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && !blocked) begin
                grant    = '0;
                grant[i] = 1'b1;
                grant_id = 3'(i);
                grant_any = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rwp_ram.sv
// Word-wide static RAM with byte write enables
`timescale 1ns/1ps
`default_nettype none
module rwp_ram #(
    parameter int WORDS = 3072,
    parameter int AW    = 12
) (
    // Clock
    input  wire logic          mclk,
    // Port
    input  wire logic          en,
    input  wire logic [3:0]    we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [31:0]   wdata,
    output logic [31:0]        rdata
);
    import rwp_pkg::*;

    logic [31:0] mem [0:WORDS-1];

    // Synchronous read; byte lanes written independently
    always_ff @(posedge mclk) begin
        if (en) begin
            for (int b = 0; b < 4; b++) begin
                if (we[b]) begin
                    mem[addr][8*b +: 8] <= wdata[8*b +: 8];
                end
            end
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire

// >>> rwp_checker.sv
// Port-level checks on the RAM subsystem
`timescale 1ns/1ps
`default_nettype none
module rwp_checker
    import rwp_pkg::*;
(
    // Clock and reset
    input wire logic               mclk,
    input wire logic               reset_n,
    // AHB slave
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic [3:0]         hprot,
    input wire logic               hreadyin,
    input wire logic               hready,
    input wire logic [1:0]         hresp,
    // DMA
    input wire logic [NUM_DMA-1:0] dma_req,
    input wire logic [NUM_DMA-1:0] dma_write,
    input wire logic [NUM_DMA-1:0] dma_grant,
    input wire logic [NUM_DMA-1:0] dma_rvalid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic in_ram;
    // Accepted address phase and RAM decode
    assign take   = hsel && hreadyin && htrans[1] && hready;
    assign in_ram = (haddr >= RAM_BASE) && (haddr < RAM_BASE + 32'(RAM_BYTES));
    sequence s_read;       take && !hwrite && in_ram; endsequence
    sequence s_priv_write; take && hwrite && hprot[1] && in_ram; endsequence
    sequence s_okay;       hresp == HRESP_OKAY; endsequence
    sequence s_err_first;  hresp == HRESP_ERROR && !hready; endsequence
    sequence s_dma_read;   (dma_grant & ~dma_write) != '0; endsequence
    property p_read_ok;   s_read |=> s_okay; endproperty
    property p_priv_ok;   s_priv_write |=> s_okay; endproperty
    property p_outside;   take && !in_ram |=> s_err_first; endproperty
    property p_err_two;   s_err_first |=> hresp == HRESP_ERROR && hready; endproperty
    property p_wait;      !hready |-> ##[1:2] hready; endproperty
    property p_onehot;    $onehot0(dma_grant); endproperty
    property p_grant_req; (dma_grant & ~dma_req) == '0; endproperty
    property p_prio;      dma_grant != '0 |-> (dma_req & (dma_grant - NUM_DMA'(1))) == '0;
    endproperty
    property p_rvalid;    s_dma_read |=> dma_rvalid == $past(dma_grant); endproperty
    a_read_ok:   assert property (p_read_ok) else $error("read refused");
    a_priv_ok:   assert property (p_priv_ok) else $error("privileged write refused");
    a_outside:   assert property (p_outside) else $error("outside RAM not refused");
    a_err_two:   assert property (p_err_two) else $error("error response shape");
    a_wait:      assert property (p_wait) else $error("too many wait states");
    a_onehot:    assert property (p_onehot) else $error("grant not one-hot");
    a_grant_req: assert property (p_grant_req) else $error("grant without request");
    a_prio:      assert property (p_prio) else $error("priority order broken");
    a_rvalid:    assert property (p_rvalid) else $error("read data valid late");
endmodule
bind rwp_top rwp_checker u_chk (
    .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hprot(hprot), .hreadyin(hreadyin), .hready(hready), .hresp(hresp),
    .dma_req(dma_req), .dma_write(dma_write), .dma_grant(dma_grant), .dma_rvalid(dma_rvalid)
);
`default_nettype wire

// >>> rwp_dma_model.sv
// Peripheral DMA masters: each holds its request until granted
`timescale 1ns/1ps
`default_nettype none
module rwp_dma_model
    import rwp_pkg::*;
(
    // Clock
    input  wire logic               mclk,
    // Requests towards the RAM
    output var logic [NUM_DMA-1:0]  dma_req,
    output var logic [NUM_DMA-1:0]  dma_write,
    output var logic [31:0]         dma_addr [NUM_DMA],
    output var logic [31:0]         dma_wdata [NUM_DMA],
    // Answers
    input  wire logic [NUM_DMA-1:0] dma_grant,
    input  wire logic [NUM_DMA-1:0] dma_rvalid,
    input  wire logic [31:0]        dma_rdata
);
    logic [31:0] got [NUM_DMA];
    int          order [$];
    initial begin
        dma_req   = '0;
        dma_write = '0;
        foreach (dma_addr[i]) dma_addr[i] = 32'h0;
        foreach (dma_wdata[i]) dma_wdata[i] = 32'h0;
    end
    // Raise one request just after an edge
    task automatic issue(input int ch, input logic wr, input logic [31:0] a, input logic [31:0] d);
        dma_write[ch] <= wr;
        dma_addr[ch]  <= a;
        dma_wdata[ch] <= d;
        dma_req[ch]   <= 1'b1;
    endtask
    // Release on grant; stale address and data are scrambled so nothing leans on them
    always @(posedge mclk) begin
        for (int i = 0; i < NUM_DMA; i++) begin
            if (dma_req[i] && dma_grant[i]) begin
                dma_req[i]   <= 1'b0;
                dma_addr[i]  <= ~dma_addr[i];
                dma_wdata[i] <= ~dma_wdata[i];
                order.push_back(i);
            end
            if (dma_rvalid[i]) got[i] <= dma_rdata;
        end
    end
endmodule
`default_nettype wire

// >>> ram_write_protect_dma_arbiter_bench.sv
// Self-checking bench for the RAM subsystem
`timescale 1ns/1ps
`default_nettype none
module ram_write_protect_dma_arbiter_bench;
    import rwp_pkg::*;
    localparam logic [31:0] B = RAM_BASE;
    logic               mclk = 1'b0, reset_n = 1'b0;
    logic               hsel = 1'b0, hwrite = 1'b0, hreadyin = 1'b1;
    logic [31:0]        haddr = '0, hwdata = '0, paddr = '0, pwdata = '0;
    logic [1:0]         htrans = '0;
    logic [2:0]         hsize = 3'h2;
    logic [3:0]         hprot = '0;
    logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]        hrdata, prdata, dma_rdata, rd;
    logic               hready, pready, pslverr, irq, perr;
    logic [1:0]         hresp, rsp;
    logic [NUM_DMA-1:0] dma_req, dma_write, dma_grant, dma_rvalid;
    logic [31:0]        dma_addr [NUM_DMA];
    logic [31:0]        dma_wdata [NUM_DMA];
    int                 n_errors = 0, check_count = 0, waits;
    // 20 MHz clock
    always #25 mclk = ~mclk;
    rwp_top u_dut (
        .mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata), .hreadyin(hreadyin),
        .hrdata(hrdata), .hready(hready), .hresp(hresp), .dma_req(dma_req),
        .dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .dma_grant(dma_grant), .dma_rvalid(dma_rvalid), .dma_rdata(dma_rdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq)
    );
    rwp_dma_model u_dma (
        .mclk(mclk), .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr),
        .dma_wdata(dma_wdata), .dma_grant(dma_grant), .dma_rvalid(dma_rvalid),
        .dma_rdata(dma_rdata)
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] ra(input logic [11:0] off);
        return PERIPH_BASE | {20'h0, off};
    endfunction
    // Register access: setup, then access until pready
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Single AHB transfer; waits counts data-phase cycles with hready low
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                       input logic [3:0] prot, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; hwrite <= wr; haddr <= a;
        hsize <= sz; hprot <= prot;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        waits = 0;
        do begin @(posedge mclk); waits++; end while (hready !== 1'b1);
        waits--;
        rd = hrdata;
        rsp = hresp;
    endtask
    // One DMA request, waited out until released and answered
    task automatic dma(input int ch, input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        u_dma.issue(ch, wr, a, d);
        do @(posedge mclk); while (dma_req[ch] !== 1'b0);
        @(posedge mclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < MAP_REGS; i++) begin
            apb(1'b0, ra(REG_MAP0) + 32'(4 * i), '0);
            check("map", rd, '0);
        end
        apb(1'b0, ra(REG_CTRL), '0);
        check("ctrl", rd, '0);
        check("irq", 32'(irq), '0);
        apb(1'b0, ra(12'h060), '0);
        check("unmapped", 32'(perr), 32'h1);
        apb(1'b1, ra(REG_MASK) + 32'h2, 32'h3);
        apb(1'b0, ra(REG_MASK), '0);
        check("misaligned", rd, '0);
    endtask
    task automatic t_ram;
        ahb(1'b1, B + 32'h100, 3'h2, 4'h1, 32'h1234_5678);
        ahb(1'b1, B + 32'h101, HSIZE_BYTE, 4'h1, 32'h0000_ab00);
        ahb(1'b1, B + 32'h102, HSIZE_HALF, 4'h1, 32'hcdef_0000);
        ahb(1'b0, B + 32'h100, 3'h2, 4'h2, '0);
        check("lanes", rd, 32'hcdef_ab78);
        check("waits", 32'(waits), '0);
        ahb(1'b1, B + 32'h2ffc, 3'h2, 4'h1, 32'h0bad_cafe);
        ahb(1'b0, B + 32'h2ffc, 3'h2, 4'h1, '0);
        check("top word", rd, 32'h0bad_cafe);
        ahb(1'b0, B + 32'(RAM_BYTES), 3'h2, 4'h3, '0);
        check("outside", 32'(rsp), 32'(HRESP_ERROR));
        apb(1'b1, ra(REG_CTRL), 32'h2);
        ahb(1'b0, B + 32'h100, 3'h2, 4'h1, '0);
        check("fast read", 32'(waits), 32'(WAIT_STATES_FAST));
        ahb(1'b1, B + 32'h104, 3'h2, 4'h1, '0);
        check("fast write", 32'(waits), 32'(WAIT_STATES_FAST));
        apb(1'b1, ra(REG_CTRL), '0);
    endtask
    task automatic t_protect;
        apb(1'b1, ra(REG_MAP0), 32'h2);
        apb(1'b1, ra(REG_MAP0) + 32'h2c, 32'h8000_0000);
        ahb(1'b1, B + 32'h3c, 3'h2, 4'h3, 32'h5555_aaaa);
        check("priv write", 32'(rsp), 32'(HRESP_OKAY));
        ahb(1'b1, B + 32'h3c, 3'h2, 4'h1, 32'h1);
        check("user write", 32'(rsp), 32'(HRESP_ERROR));
        ahb(1'b0, B + 32'h3c, 3'h2, 4'h1, '0);
        check("kept", rd, 32'h5555_aaaa);
        ahb(1'b1, B + 32'h40, 3'h2, 4'h1, 32'h2);
        check("next block", 32'(rsp), 32'(HRESP_OKAY));
        ahb(1'b1, B + 32'h1c, 3'h2, 4'h1, 32'h3);
        check("prior block", 32'(rsp), 32'(HRESP_OKAY));
        ahb(1'b1, B + 32'h2fe0, 3'h2, 4'h1, 32'h4);
        check("last block", 32'(rsp), 32'(HRESP_ERROR));
        apb(1'b0, ra(REG_STATUS), '0);
        check("bus fault", rd, 32'h2);
        apb(1'b1, ra(REG_MASK), 32'h2);
        @(posedge mclk);
        check("irq on", 32'(irq), 32'h1);
        apb(1'b1, ra(REG_STATUS), 32'h2);
        @(posedge mclk);
        check("irq off", 32'(irq), '0);
    endtask
    task automatic t_dma;
        ahb(1'b1, B + 32'h200, 3'h2, 4'h3, 32'h5a5a_0001);
        @(posedge mclk);
        for (int i = 0; i < NUM_DMA; i++) begin
            u_dma.issue(i, DMA_WRITERS[i], DMA_WRITERS[i] ? B + 32'h300 + 32'(4 * i) :
                        B + 32'h200, 32'h00d0 + 32'(i));
        end
        repeat (NUM_DMA + 3) @(posedge mclk);
        for (int i = 0; i < NUM_DMA; i++) begin
            check("order", 32'(u_dma.order[i]), 32'(i));
            if (DMA_WRITERS[i]) begin
                ahb(1'b0, B + 32'h300 + 32'(4 * i), 3'h2, 4'h3, '0);
                check("dma write", rd, 32'h00d0 + 32'(i));
            end else begin
                check("dma read", u_dma.got[i], 32'h5a5a_0001);
            end
        end
    endtask
    task automatic t_fault;
        apb(1'b1, ra(REG_MAP0), 32'h4);
        ahb(1'b1, B + 32'h48, 3'h2, 4'h3, 32'h7777_0000);
        dma(2, 1'b1, B + 32'h44, 32'h1111_0000);
        ahb(1'b0, B + 32'h44, 3'h2, 4'h3, '0);
        check("unchecked", rd, 32'h1111_0000);
        apb(1'b1, ra(REG_CTRL), 32'h1);
        apb(1'b1, ra(REG_MASK), 32'h1);
        dma(4, 1'b1, B + 32'h48, 32'h2222_0000);
        check("dma irq", 32'(irq), 32'h1);
        ahb(1'b0, B + 32'h48, 3'h2, 4'h3, '0);
        check("dropped", rd, 32'h7777_0000);
        apb(1'b0, ra(REG_FAULT_ADDR), '0);
        check("fault addr", rd & 32'h3fff, 32'h48);
        apb(1'b0, ra(REG_FAULT_ID), '0);
        check("fault id", rd, 32'(CH_SC2_RX));
        apb(1'b1, ra(REG_STATUS), 32'h1);
        dma(3, 1'b0, B + 32'h44, '0);
        apb(1'b0, ra(REG_STATUS), '0);
        check("reader", rd, '0);
        apb(1'b1, ra(REG_MASK), '0);
        dma(0, 1'b1, B + 32'h40, 32'h9);
        check("masked", 32'(irq), '0);
        apb(1'b0, ra(REG_STATUS), '0);
        check("status", rd, 32'h1);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Main sequence after two reset cycles
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_ram();
        t_protect();
        t_dma();
        t_fault();
        end_of_test();
    end
    // Watchdog against a hang
    initial begin
        #(5000 * 50);
        n_errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
